// ==== include/cbad_pkg.sv ====
/*
 * Package for the context bank attribute decoder: register offsets, field
 * positions, reset values, context types and shareability encodings.
 * Assumes a single 250 MHz clock domain and a plain strobe register port.
 */
`default_nettype none

package cbad_pkg;

  // Register map; each register is one aligned 32-bit word.
  localparam logic [7:0] CBAD_ADDR_ATTR = 8'h00;
  localparam logic [7:0] CBAD_ADDR_EXT = 8'h04;
  localparam logic [7:0] CBAD_ADDR_GCTL = 8'h08;
  localparam logic [7:0] CBAD_ADDR_ID = 8'h0c;
  localparam logic [7:0] CBAD_ADDR_STAT = 8'h10;
  localparam logic [7:0] CBAD_ADDR_BSEL = 8'h14;

  // Attribute register fields.
  localparam int CBAD_IRQ_LSB = 24;
  localparam int CBAD_TYPE_LSB = 16;
  localparam int CBAD_BANK_LSB = 8;
  localparam int CBAD_HEC_BIT = 10;
  localparam int CBAD_BSH_LSB = 8;
  localparam int CBAD_VMID_LSB = 0;

  // Extended attribute register fields.
  localparam int CBAD_WVMID_LSB = 16;
  localparam int CBAD_MONITOR_CONTEXT_BIT = 1;
  localparam int CBAD_WIDE_BIT = 0;

  // Global control bits.
  localparam int CBAD_HYP_BIT = 0;
  localparam int CBAD_WVEN_BIT = 1;

  // Implementation options.
  localparam int CBAD_NBANKS = 4;
  localparam int CBAD_BIDX_W = 2;
  localparam logic [7:0] CBAD_S2_ONLY_CNT = 8'h01;
  localparam logic [7:0] CBAD_IRQ_CNT = 8'h04;
  localparam logic CBAD_HE_SUPPORTED = 1'b1;
  localparam logic CBAD_BSH_SUPPORTED = 1'b1;
  localparam logic CBAD_TWO_SEC = 1'b1;
  localparam logic CBAD_SEC_VMID = 1'b0;
  localparam logic [31:0] CBAD_ATTR_RST = 32'h0000_0000;
  localparam logic [31:0] CBAD_EXT_RST = 32'h0000_0000;

  // Context types.
  typedef enum logic [1:0] {
    CBAD_S2_ONLY = 2'b00,
    CBAD_S1_BYPASS = 2'b01,
    CBAD_S1_FAULT = 2'b10,
    CBAD_S1_S2 = 2'b11
  } cbad_type_t;

  // Shareability encodings used by the bypass field.
  localparam logic [1:0] CBAD_SH_RSVD = 2'b00;
  localparam logic [1:0] CBAD_SH_OUTER = 2'b01;
  localparam logic [1:0] CBAD_SH_INNER = 2'b10;
  localparam logic [1:0] CBAD_SH_NONE = 2'b11;

  // Translation request from a bus master and its routed result.
  typedef struct packed {
    logic [1:0] bank;
    logic [1:0] s1_share;
    logic secure;
    logic global_map;
    logic [15:0] asid;
  } cbad_req_t;

  typedef struct packed {
    logic do_s1;
    logic do_s2;
    logic fault;
    logic [1:0] s2_bank;
    logic [1:0] share;
    logic [15:0] vmid;
    logic he_tag;
    logic asid_tag;
    logic [15:0] asid;
    logic [7:0] irq;
    logic unpred;
  } cbad_rsp_t;

endpackage : cbad_pkg

`default_nettype wire

// ==== rtl/cbad_top.sv ====
/*
 * Context bank attribute decoder: holds the per-bank attribute and extended
 * attribute registers, decodes the context type for each bus master request
 * and produces the routed translation result one cycle later.
 * Assumes requests and register strobes are synchronous to clk_sys.
 */
// The register offsets and the address-and-strobe port were left to the implementer.
// Operation
// R1 - Decode two-bit context type into four modes
// R2 - Bit 10 host-extension only if supported, hypervisor-mode
// R3 - Host-extension entries tagged; non-global carry ASID
// R4 - Software avoids host-ext, monitor, wide on Secure
// R5 - Bypass shareability bits 9:8 encoding
// R6 - Combine shareability by taking wider domain
// R7 - Unsupported bypass shareability reads zero, ignores writes
// R8 - VM id from bits 7:0 or wide field
// R9 - Secure bank VM id ignored without support
// R10 - Fault type raises invalid context fault
// R11 - Fault format field layout with reserved bits
// R12 - Interrupt index selects context interrupt number
// R13 - Nested type uses bits 15:8 stage 2 bank
// R14 - Software points nested index at stage-2 bank
// R15 - Unused upper bank index bits read zero
// R16 - Software matches nested VM id with stage 2
// R17 - Identification register reports stage-2-only bank count
// R18 - Extended write retries a stalled transaction
// R19 - Extended attribute register is 32-bit read-write
// R20 - Reserved attribute bits read zero, writes dropped
`timescale 1ns/10ps
`default_nettype none

module cbad_top
  import cbad_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [CBAD_NBANKS-1:0] bank_secure,
  input wire logic [CBAD_NBANKS-1:0] stall_set,
  input wire logic req_valid,
  input wire cbad_req_t req,
  output logic rsp_valid,
  output cbad_rsp_t rsp,
  output logic [CBAD_NBANKS-1:0] retry_pulse
);

  ////////////////////////////////////////////////////////////////////////////
  // Storage.

  logic [31:0] attr_r [CBAD_NBANKS];
  logic [31:0] ext_r [CBAD_NBANKS];
  logic [1:0] gctl_r;
  logic [CBAD_NBANKS-1:0] stall_r;
  logic [CBAD_BIDX_W-1:0] bsel_r;
  logic [31:0] rdata_nxt;
  cbad_rsp_t rsp_nxt;

  // Keeps only the bits each context type really implements.
  function automatic logic [31:0] attr_mask(input logic [31:0] v,
                                            input logic hyp);
    logic [31:0] m;
    m = 32'h0000_0000;
    m[CBAD_IRQ_LSB +: 8] = 8'hff; // R12
    m[CBAD_TYPE_LSB +: 2] = 2'b11;
    m[CBAD_VMID_LSB +: 8] = 8'hff;
    case (cbad_type_t'(v[CBAD_TYPE_LSB +: 2]))
      CBAD_S1_BYPASS: begin
        m[CBAD_HEC_BIT] = CBAD_HE_SUPPORTED & hyp; // R2
        m[CBAD_BSH_LSB +: 2] = {2{CBAD_BSH_SUPPORTED}}; // R7
      end
      CBAD_S1_FAULT: m[CBAD_VMID_LSB +: 8] = 8'h00; // R11
      CBAD_S1_S2: m[CBAD_BANK_LSB +: CBAD_BIDX_W] = '1; // R13 R15
      default: m[CBAD_VMID_LSB +: 8] = 8'hff;
    endcase
    attr_mask = v & m; // R20
  endfunction : attr_mask

  // Wider of two shareability domains: outer over inner over none.
  function automatic logic [1:0] wider_sh(input logic [1:0] a,
                                          input logic [1:0] b);
    if (a == CBAD_SH_OUTER || b == CBAD_SH_OUTER) begin
      wider_sh = CBAD_SH_OUTER;
    end else if (a == CBAD_SH_INNER || b == CBAD_SH_INNER) begin
      wider_sh = CBAD_SH_INNER;
    end else begin
      wider_sh = CBAD_SH_NONE;
    end
  endfunction : wider_sh

  ////////////////////////////////////////////////////////////////////////////
  // Register writes.

  // Attribute and extended registers are written through a bank select.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      for (int i = 0; i < CBAD_NBANKS; i++) begin
        attr_r[i] <= CBAD_ATTR_RST;
        ext_r[i] <= CBAD_EXT_RST;
      end
    end else if (reg_wr) begin
      if (reg_addr == CBAD_ADDR_ATTR) begin
        attr_r[bsel_r] <= attr_mask(reg_wdata, gctl_r[CBAD_HYP_BIT]); // R20
      end
      if (reg_addr == CBAD_ADDR_EXT) begin
        ext_r[bsel_r] <= reg_wdata; // R19
      end
    end
  end

  // Global control and bank select.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      gctl_r <= 2'b00;
      bsel_r <= '0;
    end else if (reg_wr && reg_addr == CBAD_ADDR_GCTL) begin
      gctl_r <= reg_wdata[1:0];
    end else if (reg_wr && reg_addr == CBAD_ADDR_BSEL) begin
      bsel_r <= reg_wdata[CBAD_BIDX_W-1:0];
    end
  end

  // Stall flags: an extended write releases the stall and retries it; a new
  // stall arriving in the same cycle wins so it is not lost.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      stall_r <= '0;
      retry_pulse <= '0;
    end else begin
      for (int i = 0; i < CBAD_NBANKS; i++) begin
        retry_pulse[i] <= reg_wr && reg_addr == CBAD_ADDR_EXT &&
                          bsel_r == CBAD_BIDX_W'(i) && stall_r[i]; // R18
        if (stall_set[i]) begin
          stall_r[i] <= 1'b1;
        end else if (reg_wr && reg_addr == CBAD_ADDR_EXT &&
                     bsel_r == CBAD_BIDX_W'(i)) begin
          stall_r[i] <= 1'b0; // R18
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register reads; unmapped addresses read zero.

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    case (reg_addr)
      CBAD_ADDR_ATTR: rdata_nxt = attr_r[bsel_r];
      CBAD_ADDR_EXT: rdata_nxt = ext_r[bsel_r];
      CBAD_ADDR_GCTL: rdata_nxt = {30'h0, gctl_r};
      CBAD_ADDR_ID: rdata_nxt = {16'h0, CBAD_IRQ_CNT, CBAD_S2_ONLY_CNT}; // R17
      CBAD_ADDR_STAT: rdata_nxt = {{(32-CBAD_NBANKS){1'b0}}, stall_r};
      CBAD_ADDR_BSEL: rdata_nxt = {{(32-CBAD_BIDX_W){1'b0}}, bsel_r};
      default: rdata_nxt = 32'h0000_0000;
    endcase
  end

  // Read data stands only in the cycle after the strobe.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= reg_rd ? rdata_nxt : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Request decode.

  always_comb begin
    logic [31:0] a;
    logic [31:0] e;
    logic [1:0] bsh;
    cbad_type_t ty;
    logic sec;
    a = attr_r[req.bank];
    e = ext_r[req.bank];
    ty = cbad_type_t'(a[CBAD_TYPE_LSB +: 2]);
    bsh = a[CBAD_BSH_LSB +: 2];
    // A bank counts as secure if its pin or the request says so.
    sec = req.secure | bank_secure[req.bank];
    rsp_nxt = '0;
    rsp_nxt.irq = a[CBAD_IRQ_LSB +: 8]; // R12
    rsp_nxt.asid = req.asid;
    rsp_nxt.share = req.s1_share;
    // Pick the 8-bit or wide VM identifier.
    if (gctl_r[CBAD_WVEN_BIT]) begin
      rsp_nxt.vmid = e[CBAD_WVMID_LSB +: 16]; // R8
    end else begin
      rsp_nxt.vmid = {8'h00, a[CBAD_VMID_LSB +: 8]}; // R8
    end
    if (CBAD_TWO_SEC && !CBAD_SEC_VMID && sec) begin
      rsp_nxt.vmid = 16'h0000; // R9
    end
    case (ty)
      CBAD_S2_ONLY: rsp_nxt.do_s2 = 1'b1; // R1
      CBAD_S1_BYPASS: begin
        rsp_nxt.do_s1 = 1'b1; // R1
        if (bsh != CBAD_SH_RSVD) begin
          rsp_nxt.share = wider_sh(req.s1_share, bsh); // R5 R6
        end
        rsp_nxt.he_tag = a[CBAD_HEC_BIT] & CBAD_HE_SUPPORTED &
                         gctl_r[CBAD_HYP_BIT]; // R2 R3
        rsp_nxt.asid_tag = rsp_nxt.he_tag & ~req.global_map; // R3
        rsp_nxt.unpred = sec & rsp_nxt.he_tag &
                         e[CBAD_MONITOR_CONTEXT_BIT] & e[CBAD_WIDE_BIT]; // R4
      end
      CBAD_S1_FAULT: rsp_nxt.fault = 1'b1; // R10
      CBAD_S1_S2: begin
        rsp_nxt.do_s1 = 1'b1; // R13
        rsp_nxt.do_s2 = 1'b1;
        rsp_nxt.s2_bank = a[CBAD_BANK_LSB +: CBAD_BIDX_W]; // R13
        rsp_nxt.unpred =
          attr_r[rsp_nxt.s2_bank][CBAD_TYPE_LSB +: 2] != CBAD_S2_ONLY; // R14
      end
      default: rsp_nxt.fault = 1'b1;
    endcase
  end

  // Result register.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      rsp_valid <= 1'b0;
      rsp <= '0;
    end else begin
      rsp_valid <= req_valid;
      rsp <= rsp_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  sequence s_fault_req;
    req_valid && attr_r[req.bank][17:16] == 2'b10;
  endsequence

  a_fault_type: assert property (@(posedge clk_sys) disable iff (!rstn) // R10
    s_fault_req |=> rsp_valid && rsp.fault && !rsp.do_s1)
    else $error("fault type did not fault");
  a_s2_only: assert property (@(posedge clk_sys) disable iff (!rstn) // R1
    req_valid && attr_r[req.bank][17:16] == 2'b00 |=> rsp.do_s2 && !rsp.do_s1)
    else $error("stage 2 only decode wrong");
  a_share_outer: assert property (@(posedge clk_sys) disable iff (!rstn) // R6
    req_valid && req.s1_share == 2'b01 |=> rsp.share == 2'b01)
    else $error("outer shareability lost");
  a_nested_bank: assert property (@(posedge clk_sys) disable iff (!rstn) // R13
    req_valid && attr_r[req.bank][17:16] == 2'b11
    |=> rsp.s2_bank == $past(attr_r[req.bank][9:8]))
    else $error("nested stage 2 bank wrong");
  a_he_gate: assert property (@(posedge clk_sys) disable iff (!rstn) // R2
    !gctl_r[0] |=> !rsp.he_tag || $past(gctl_r[0]))
    else $error("host extension tag without mode");
  a_asid_tag: assert property (@(posedge clk_sys) disable iff (!rstn) // R3
    rsp.asid_tag |-> rsp.he_tag)
    else $error("asid tag without host extension");
  a_retry_ext: assert property (@(posedge clk_sys) disable iff (!rstn) // R18
    reg_wr && reg_addr == 8'h04 && stall_r[bsel_r] && !stall_set[bsel_r]
    |=> retry_pulse != '0 && !stall_r[$past(bsel_r)])
    else $error("stalled transaction not retried");
  a_id_read: assert property (@(posedge clk_sys) disable iff (!rstn) // R17
    reg_rd && reg_addr == 8'h0c |=> reg_rdata[7:0] == 8'h01)
    else $error("stage 2 only count wrong");
  a_rsvd_zero: assert property (@(posedge clk_sys) disable iff (!rstn) // R20
    reg_rd && reg_addr == 8'h00 |=> reg_rdata[23:20] == 4'h0)
    else $error("reserved attribute bits set");

endmodule : cbad_top

`default_nettype wire

// ==== verification/cbad_master_model.sv ====
/*
 * Bus master model: issues one translation request per go pulse.
 * Assumes go and want change just after a rising clock edge.
 */
`timescale 1ns/10ps
`default_nettype none

module cbad_master_model
  import cbad_pkg::*;
(
  input wire logic clk_sys,
  input wire logic go,
  input wire cbad_req_t want,
  output logic req_valid,
  output cbad_req_t req
);
  // Idle fields toggle each cycle, so a decoder using stale fields fails.
  always_ff @(posedge clk_sys) begin
    req_valid <= go;
    req <= go ? want : ~req;
  end
endmodule : cbad_master_model

`default_nettype wire

// ==== verification/context_bank_attribute_decode_test.sv ====
/*
 * Self-checking bench for the attribute decoder, one task per scenario.
 * Assumes the package, the decoder and the master model compile first.
 */
`timescale 1ns/10ps
`default_nettype none
`define CBAD_CHK(a, b) begin compares++; if ((a) !== (b)) begin err_total++; \
  $display("wrong value at %0t: %h versus %h", $time, a, b); end end

module context_bank_attribute_decode_test
  import cbad_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [3:0] stall_set = 4'h0;
  logic [3:0] bank_secure = 4'h0;
  logic go = 1'b0;
  cbad_req_t want = '0;
  logic req_valid;
  cbad_req_t req;
  logic rsp_valid;
  cbad_rsp_t rsp;
  logic [3:0] retry_pulse;
  cbad_rsp_t o;
  int err_total = 0;
  int compares = 0;
  int cyc = 0;

  cbad_top cbad_top_inst (.clk_sys(clk_sys), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bank_secure(bank_secure),
    .stall_set(stall_set), .req_valid(req_valid), .req(req),
    .rsp_valid(rsp_valid), .rsp(rsp), .retry_pulse(retry_pulse));
  cbad_master_model cbad_master_model_inst (.clk_sys(clk_sys), .go(go),
    .want(want), .req_valid(req_valid), .req(req));

  // A 4 ns clock; the cycle ceiling is far above the roughly 140 needed.
  always #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 4000) begin
      err_total++;
      report_and_stop();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus tasks: strobes are one cycle and the read word is taken once.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    `CBAD_CHK(reg_rdata, e)
  endtask : rdc

  // The response is awaited under a bound of four cycles.
  task automatic rq(input cbad_req_t r);
    int n;
    @(posedge clk_sys);
    want <= r;
    go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_sys);
      #1;
      n++;
    end while (rsp_valid !== 1'b1 && n < 4);
    `CBAD_CHK(rsp_valid, 1'b1)
    o = rsp;
  endtask : rq

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rdc(CBAD_ADDR_ID, 32'h0000_0401);
    rdc(CBAD_ADDR_ATTR, 32'h0);
    rdc(8'h20, 32'h0);
  endtask : t_reset

  // Reserved bits are written as ones and must come back as zero.
  task automatic t_fault();
    wr(CBAD_ADDR_BSEL, 32'h1);
    wr(CBAD_ADDR_ATTR, 32'h03f2_ffff);
    rdc(CBAD_ADDR_ATTR, 32'h0302_0000);
    rq('{2'd1, 2'b11, 1'b0, 1'b1, 16'h0});
    `CBAD_CHK(o.fault, 1'b1)
    `CBAD_CHK(o.irq, 8'h03)
  endtask : t_fault

  // Smaller codes are wider domains; the reserved code keeps stage 1.
  task automatic t_share();
    logic [1:0] b;
    logic [1:0] s;
    wr(CBAD_ADDR_BSEL, 32'h2);
    for (int i = 0; i < 4; i++) begin
      b = 2'(i);
      wr(CBAD_ADDR_ATTR, {14'h0, 2'b01, 6'h0, b, 8'h0});
      for (int j = 1; j < 4; j++) begin
        s = 2'(j);
        rq('{2'd2, s, 1'b0, 1'b1, 16'h0});
        `CBAD_CHK(o.share, (b == 2'b00 || s < b) ? s : b)
        `CBAD_CHK(o.do_s1, 1'b1)
      end
    end
  endtask : t_share

  // Bank 2 is non-secure, so the host, monitor, wide trio is legal.
  task automatic t_host();
    wr(CBAD_ADDR_GCTL, 32'h1);
    wr(CBAD_ADDR_ATTR, 32'h0001_0400);
    wr(CBAD_ADDR_EXT, 32'h3);
    rq('{2'd2, 2'b11, 1'b0, 1'b0, 16'h1234});
    `CBAD_CHK({o.he_tag, o.asid_tag, o.asid}, {2'b11, 16'h1234})
    `CBAD_CHK(o.unpred, 1'b0)
    wr(CBAD_ADDR_GCTL, 32'h0);
    wr(CBAD_ADDR_ATTR, 32'h0001_0400);
    rq('{2'd2, 2'b11, 1'b0, 1'b0, 16'h1234});
    `CBAD_CHK(o.he_tag, 1'b0)
  endtask : t_host

  // Nested bank 3 points at stage 2 bank 0 with the same identifier.
  task automatic t_nest();
    wr(CBAD_ADDR_BSEL, 32'h3);
    wr(CBAD_ADDR_ATTR, 32'h0003_ff00);
    rdc(CBAD_ADDR_ATTR, 32'h0003_0300);
    wr(CBAD_ADDR_ATTR, 32'h0003_0000);
    rq('{2'd3, 2'b11, 1'b0, 1'b1, 16'h0});
    `CBAD_CHK({o.do_s1, o.do_s2, o.s2_bank}, 4'b1100)
    `CBAD_CHK(o.unpred, 1'b0)
  endtask : t_nest

  task automatic t_vmid();
    wr(CBAD_ADDR_BSEL, 32'h0);
    wr(CBAD_ADDR_ATTR, 32'h0000_005a);
    rq('{2'd0, 2'b11, 1'b0, 1'b1, 16'h0});
    `CBAD_CHK({o.do_s1, o.do_s2, o.vmid}, {2'b01, 16'h005a})
    rq('{2'd0, 2'b11, 1'b1, 1'b1, 16'h0});
    `CBAD_CHK(o.vmid, 16'h0)
    // The bank's own secure pin must hide the identifier as well.
    @(posedge clk_sys);
    bank_secure <= 4'h1;
    rq('{2'd0, 2'b11, 1'b0, 1'b1, 16'h0});
    `CBAD_CHK(o.vmid, 16'h0)
    @(posedge clk_sys);
    bank_secure <= 4'h0;
    wr(CBAD_ADDR_GCTL, 32'h2);
    wr(CBAD_ADDR_EXT, 32'hbeef_0003);
    rdc(CBAD_ADDR_EXT, 32'hbeef_0003);
    rq('{2'd0, 2'b11, 1'b0, 1'b1, 16'h0});
    `CBAD_CHK(o.vmid, 16'hbeef)
  endtask : t_vmid

  // A stalled bank is retried by an extended write, one pulse only.
  task automatic t_retry();
    @(posedge clk_sys);
    stall_set <= 4'h1;
    @(posedge clk_sys);
    stall_set <= 4'h0;
    rdc(CBAD_ADDR_STAT, 32'h1);
    wr(CBAD_ADDR_EXT, 32'h0);
    #1;
    `CBAD_CHK(retry_pulse, 4'h1)
    @(posedge clk_sys);
    #1;
    `CBAD_CHK(retry_pulse, 4'h0)
    rdc(CBAD_ADDR_STAT, 32'h0);
    // A stall that lands with the extended write must not be lost.
    @(posedge clk_sys);
    reg_addr <= CBAD_ADDR_EXT;
    reg_wdata <= 32'h0;
    reg_wr <= 1'b1;
    stall_set <= 4'h1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    stall_set <= 4'h0;
    rdc(CBAD_ADDR_STAT, 32'h1);
  endtask : t_retry

  task automatic report_and_stop();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (12) @(posedge clk_sys);
    rstn <= 1'b1;
    t_reset();
    t_fault();
    t_share();
    t_host();
    t_nest();
    t_vmid();
    t_retry();
    report_and_stop();
  end
endmodule : context_bank_attribute_decode_test

`default_nettype wire
